// ===== verilog/stc1_pkg.sv
// Constants and carriers for the sixteen-bit timer/counter.
// Assumes a plain register port with one-cycle strobes.
package stc1_pkg;
  localparam int STC1_ADDR_W = 2;
  localparam logic [1:0] STC1_OFF_CTRL = 2'h0;
  localparam logic [1:0] STC1_OFF_LOW = 2'h1;
  localparam logic [1:0] STC1_OFF_HIGH = 2'h2;
  localparam logic [1:0] STC1_OFF_FLAGS = 2'h3;
  localparam int STC1_RUN_BIT = 0;
  localparam int STC1_SRC_BIT = 1;
  localparam int STC1_SYNC_BIT = 2;
  localparam int STC1_OSC_BIT = 3;
  localparam int STC1_PS_LO = 4;
  localparam int STC1_STAT_BIT = 6;
  localparam int STC1_WIDE_BIT = 7;
  localparam int STC1_FLAG_BIT = 0;
  localparam int STC1_IEN_BIT = 1;
  localparam logic [7:0] STC1_CTRL_RST = 8'h00;
  localparam logic [7:0] STC1_CTRL_WMASK = 8'hBF;
  localparam logic [3:0] STC1_TRIG_MODE = 4'hB;
  localparam logic [15:0] STC1_CNT_RST = 16'h0000;
  localparam logic [15:0] STC1_CNT_MAX = 16'hFFFF;
  localparam int STC1_CLK_MHZ = 125;
  localparam int STC1_INSTR_DIV = 4;
  localparam logic [1:0] STC1_INSTR_LAST = 2'(STC1_INSTR_DIV - 1);

  typedef struct packed {
    logic wr;
    logic rd;
    logic [STC1_ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } stc1_bus_s;

  typedef struct packed {
    logic wide;
    logic [1:0] prescale;
    logic osc_en;
    logic sync_dis;
    logic src;
    logic run;
  } stc1_ctrl_s;
endpackage

// ===== verilog/stc1_timer.sv
// Sixteen-bit timer/counter with prescaler, overflow flag and trigger reset.
// Assumes pins are synchronous to ref_clk; the bus never waits.
// Function
// - Sixteen-bit up-counter readable and writable as low and high bytes.
// - Counting happens only while control bit 0 is set.
// - Source 0 counts instruction cycles (clock over four), ignoring sync.
// - Source 1 counts rising edges of external pin or oscillator.
// - Bit 2 clear synchronises external clock; set counts it unsynchronised.
// - Prescale field bits 5-4 divide by 1, 2, 4 or 8.
// - Oscillator enable forces both oscillator pins to inputs reading zero.
// - An enabled oscillator keeps running in every power-managed mode.
// - Read-only bit 6 shows system clock taken from the oscillator.
// - Rollover from FFFF to 0000 sets and holds the overflow flag.
// - Interrupt request only while the overflow enable is set.
// - Compare mode 1011 trigger pulses reset the counter.
// - Trigger reset never sets the overflow flag.
// - Counter write coinciding with trigger wins over the reset.
// - Control bit 7 selects buffered sixteen-bit or plain byte access.
// - Wide mode: low read latches high byte; high address reads latch.
// - Wide mode: high writes fill buffer; low write loads both bytes.
// - Low-byte writes clear the prescaler; high-byte writes do not.
`timescale 1ns/1ps
module stc1_timer
  import stc1_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire stc1_pkg::stc1_bus_s bus,
  output logic [7:0] rdata,
  input wire logic ext_count_clock_pin,
  input wire logic lp_osc_in_pin,
  input wire logic lp_osc_clock,
  input wire logic [1:0] osc_pin_direction_bits,
  input wire logic [1:0] osc_pin_out_val,
  output logic [1:0] osc_pin_out,
  output logic [1:0] osc_pin_oe_n,
  output logic [1:0] osc_pin_read,
  input wire logic sysclk_from_lp_osc,
  input wire logic power_managed_mode,
  output logic lp_osc_running,
  input wire logic [3:0] compare_mode_field,
  input wire logic special_event_trigger,
  output logic overflow_irq
);
  import stc1_pkg::*;

  stc1_ctrl_s ctrl_reg;
  logic [15:0] count_reg;
  logic [7:0] high_buf_reg;
  logic overflow_flag_reg;
  logic overflow_irq_enable_reg;
  logic [1:0] instr_div_reg;
  logic [2:0] presc_reg;
  logic ext_meta_reg;
  logic ext_sync_reg;
  logic ext_prev_reg;
  logic raw_prev_reg;
  logic [7:0] rdata_next;

  logic wr_ctrl;
  logic wr_low;
  logic wr_high;
  logic wr_flags;
  logic rd_low;
  logic ext_src;
  logic ext_edge;
  logic tick_in;
  logic presc_done;
  logic inc;
  logic trig;
  logic [2:0] presc_last;

  assign wr_ctrl = bus.wr && bus.addr == STC1_OFF_CTRL;
  assign wr_low = bus.wr && bus.addr == STC1_OFF_LOW;
  assign wr_high = bus.wr && bus.addr == STC1_OFF_HIGH;
  assign wr_flags = bus.wr && bus.addr == STC1_OFF_FLAGS;
  assign rd_low = bus.rd && bus.addr == STC1_OFF_LOW;

  // Control register, status bit is not stored
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_reg <= stc1_ctrl_s'({STC1_CTRL_RST[7], STC1_CTRL_RST[5:0]});
    end else if (wr_ctrl) begin
      ctrl_reg <= stc1_ctrl_s'({bus.wdata[7], bus.wdata[5:0]});
    end
  end

  // Oscillator pins: inputs reading zero when the oscillator is on
  assign osc_pin_oe_n = ctrl_reg.osc_en ? 2'b11 : osc_pin_direction_bits;
  assign osc_pin_out = osc_pin_out_val;
  assign osc_pin_read = 2'b00;
  assign lp_osc_running = ctrl_reg.osc_en;

  // Instruction-cycle divider, clock over four
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      instr_div_reg <= 2'h0;
    end else begin
      instr_div_reg <= instr_div_reg + 2'h1;
    end
  end

  // External source selection and synchroniser
  assign ext_src = ctrl_reg.osc_en ? lp_osc_clock : ext_count_clock_pin;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
      raw_prev_reg <= 1'b0;
    end else begin
      ext_meta_reg <= ext_src;
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
      raw_prev_reg <= ext_src;
    end
  end
  // Unsynchronised path samples the pin directly, two cycles less latency
  assign ext_edge = ctrl_reg.sync_dis ? (ext_src && !raw_prev_reg)
                                      : (ext_sync_reg && !ext_prev_reg);

  always_comb begin
    if (ctrl_reg.src) begin
      tick_in = ext_edge;
    end else begin
      tick_in = instr_div_reg == STC1_INSTR_LAST;
    end
  end

  // Prescaler
  assign presc_last = 3'((1 << ctrl_reg.prescale) - 1);
  assign presc_done = presc_reg >= presc_last;
  assign inc = ctrl_reg.run && tick_in && presc_done;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      presc_reg <= 3'h0;
    end else if (wr_low) begin
      presc_reg <= 3'h0;
    end else if (ctrl_reg.run && tick_in) begin
      presc_reg <= presc_done ? 3'h0 : presc_reg + 3'h1;
    end
  end

  assign trig = special_event_trigger &&
                compare_mode_field == STC1_TRIG_MODE;

  // Counter
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count_reg <= STC1_CNT_RST;
    end else if (wr_low && ctrl_reg.wide) begin
      count_reg <= {high_buf_reg, bus.wdata};
    end else if (wr_low) begin
      count_reg[7:0] <= bus.wdata;
    end else if (wr_high && !ctrl_reg.wide) begin
      count_reg[15:8] <= bus.wdata;
    end else if (trig) begin
      count_reg <= STC1_CNT_RST;
    end else if (inc) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // High-byte buffer for wide access
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      high_buf_reg <= 8'h00;
    end else if (wr_high && ctrl_reg.wide) begin
      high_buf_reg <= bus.wdata;
    end else if (rd_low && ctrl_reg.wide) begin
      high_buf_reg <= count_reg[15:8];
    end
  end

  // Overflow flag and enable; hardware set beats software clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      overflow_flag_reg <= 1'b0;
      overflow_irq_enable_reg <= 1'b0;
    end else begin
      if (wr_flags) begin
        overflow_irq_enable_reg <= bus.wdata[STC1_IEN_BIT];
      end
      if (inc && !trig && !wr_low && !(wr_high && !ctrl_reg.wide) &&
          count_reg == STC1_CNT_MAX) begin
        overflow_flag_reg <= 1'b1;
      end else if (wr_flags && !bus.wdata[STC1_FLAG_BIT]) begin
        overflow_flag_reg <= 1'b0;
      end
    end
  end

  assign overflow_irq = overflow_flag_reg && overflow_irq_enable_reg;

  // Read mux, data one cycle after the strobe
  always_comb begin
    rdata_next = 8'h00;
    unique case (bus.addr)
      STC1_OFF_CTRL: begin
        rdata_next = {ctrl_reg.wide, sysclk_from_lp_osc, ctrl_reg.prescale,
                      ctrl_reg.osc_en, ctrl_reg.sync_dis, ctrl_reg.src,
                      ctrl_reg.run};
      end
      STC1_OFF_LOW: begin
        rdata_next = count_reg[7:0];
      end
      STC1_OFF_HIGH: begin
        rdata_next = ctrl_reg.wide ? high_buf_reg : count_reg[15:8];
      end
      STC1_OFF_FLAGS: begin
        rdata_next = {6'h00, overflow_irq_enable_reg, overflow_flag_reg};
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      rdata <= rdata_next;
    end else begin
      rdata <= 8'h00;
    end
  end

  logic [1:0] unused_ok;
  assign unused_ok = {lp_osc_in_pin, power_managed_mode};

  // Checks
  a_trig_clears_count: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    trig && !bus.wr
    |=> count_reg == STC1_CNT_RST)
    else $error("trigger did not clear counter");

  a_write_beats_trig: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wr_low && trig && !ctrl_reg.wide
    |=> count_reg[7:0] == $past(bus.wdata))
    else $error("write lost to trigger");

  a_stop_holds_count: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !ctrl_reg.run && !bus.wr && !trig
    |=> $stable(count_reg))
    else $error("counter moved while stopped");

  a_rollover_sets_flag: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    inc && !trig && !bus.wr && count_reg == STC1_CNT_MAX
    |=> overflow_flag_reg && count_reg == STC1_CNT_RST)
    else $error("rollover missed flag");

  a_trig_no_flag: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    trig && !overflow_flag_reg && !bus.wr
    |=> !overflow_flag_reg)
    else $error("trigger set flag");

  a_irq_gated_enable: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    overflow_irq
    == (overflow_flag_reg && overflow_irq_enable_reg))
    else $error("irq not gated");

  a_low_read_latches: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rd_low && ctrl_reg.wide
    |=> high_buf_reg == $past(count_reg[15:8]))
    else $error("high byte not latched");

  a_wide_high_write: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wr_high && ctrl_reg.wide |=> $past(count_reg[15:8]) == count_reg[15:8]
    || $past(inc) || $past(trig))
    else $error("wide high write hit counter");

  a_low_write_presc: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wr_low
    |=> presc_reg == 3'h0)
    else $error("prescaler not cleared");

  a_internal_rate: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    inc && !ctrl_reg.src && !bus.wr ##1 !bus.wr[*3]
    |-> !$past(inc))
    else $error("internal count too fast");

  a_osc_pins_input: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    ctrl_reg.osc_en
    |-> osc_pin_oe_n == 2'b11 && osc_pin_read == 2'b00)
    else $error("osc pins not inputs");

  a_count_steps_one: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    inc && !trig && !bus.wr
    |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("counter did not step by one");

  a_ext_edge_counts: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    ctrl_reg.src && ctrl_reg.run && ext_edge && presc_done
    |-> inc)
    else $error("external edge not counted");

  a_sync_edge_delay: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    ctrl_reg.src && !ctrl_reg.sync_dis && !ext_src && !bus.wr
    ##1 ext_src && !bus.wr ##1 !bus.wr |=> ext_edge)
    else $error("synchronised edge late");

  a_async_edge_delay: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    ctrl_reg.sync_dis && !ext_src && !bus.wr
    ##1 ext_src |-> ext_edge)
    else $error("unsynchronised edge missed");

  a_presc_steps: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    ctrl_reg.run && tick_in && !presc_done && !wr_low
    |=> presc_reg == $past(presc_reg) + 3'h1)
    else $error("prescaler did not step");

  a_osc_keeps_running: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    ctrl_reg.osc_en && !bus.wr
    |=> lp_osc_running)
    else $error("oscillator stopped");

  a_status_read: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    bus.rd && bus.addr == STC1_OFF_CTRL
    |=> rdata[STC1_STAT_BIT] == $past(sysclk_from_lp_osc))
    else $error("status bit wrong");

  a_flag_holds: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    overflow_flag_reg && !wr_flags
    |=> overflow_flag_reg)
    else $error("overflow flag dropped");

  a_byte_high_write: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wr_high && !ctrl_reg.wide
    |=> count_reg[15:8] == $past(bus.wdata))
    else $error("byte high write lost");

  a_wide_low_load: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wr_low && ctrl_reg.wide
    |=> count_reg == {$past(high_buf_reg), $past(bus.wdata)})
    else $error("wide load wrong");

  a_high_write_presc: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wr_high |=> presc_reg == $past(presc_reg)
    || $past(ctrl_reg.run && tick_in))
    else $error("high write touched prescaler");

  a_wide_high_read: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    bus.rd && bus.addr == STC1_OFF_HIGH && ctrl_reg.wide
    |=> rdata == $past(high_buf_reg))
    else $error("wide high read not buffered");

  a_flag_clear: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wr_flags && !bus.wdata[STC1_FLAG_BIT] && count_reg != STC1_CNT_MAX
    |=> !overflow_flag_reg)
    else $error("flag not cleared");
endmodule // stc1_timer

// ===== bench/stc1_far.sv
// Far side model: external count clock source and compare trigger.
// Assumes callers run in ref_clk context; lines idle low between bursts.
`timescale 1ns/1ps
module stc1_far (
  input wire logic ref_clk,
  input wire logic use_osc,
  output logic ext_clk,
  output logic osc_clk,
  output logic trigger
);
  initial {ext_clk, osc_clk, trigger} = 3'b000;
  task automatic edges(input int n);
    repeat (n) begin
      repeat (4) @(posedge ref_clk);
      if (use_osc) begin
        osc_clk <= 1'b1;
      end else begin
        ext_clk <= 1'b1;
      end
      repeat (4) @(posedge ref_clk);
      {ext_clk, osc_clk} <= 2'b00;
    end
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic pulse();
    @(posedge ref_clk);
    trigger <= 1'b1;
    @(posedge ref_clk);
    trigger <= 1'b0;
  endtask
endmodule // stc1_far

// ===== bench/tb.sv
// Self-checking bench for the sixteen-bit timer/counter.
// Assumes stc1_far supplies count edges and trigger pulses.
`timescale 1ns/1ps
module tb;
  import stc1_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  stc1_bus_s bus = '0;
  logic [7:0] rdata;
  logic ext_count_clock_pin, lp_osc_clock, special_event_trigger;
  logic lp_osc_in_pin, use_osc, sysclk_from_lp_osc, power_managed_mode;
  logic [1:0] osc_pin_direction_bits, osc_pin_out_val;
  logic [1:0] osc_pin_out, osc_pin_oe_n, osc_pin_read;
  logic lp_osc_running, overflow_irq;
  logic [3:0] compare_mode_field;
  int err_total = 0;
  int total_checks = 0;
  stc1_timer i_stc1_timer (.ref_clk, .rst_n, .bus, .rdata,
    .ext_count_clock_pin, .lp_osc_in_pin, .lp_osc_clock,
    .osc_pin_direction_bits, .osc_pin_out_val, .osc_pin_out,
    .osc_pin_oe_n, .osc_pin_read, .sysclk_from_lp_osc,
    .power_managed_mode, .lp_osc_running, .compare_mode_field,
    .special_event_trigger, .overflow_irq);
  stc1_far i_stc1_far (.ref_clk, .use_osc, .ext_clk(ext_count_clock_pin),
    .osc_clk(lp_osc_clock), .trigger(special_event_trigger));
  always #4 ref_clk = ~ref_clk;
  function automatic logic [15:0] exp_ctl(input logic [7:0] w,
    input logic s);
    return {8'h00, (w & STC1_CTRL_WMASK) | {1'b0, s, 6'h00}};
  endfunction
  function automatic logic [15:0] scaled(input int k, input int p);
    return 16'(k >> p);
  endfunction
  task automatic chk(input string n, input logic [15:0] e,
    input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_near(input string n, input int e, input logic [15:0] g);
    total_checks++;
    if ((g >= 16'(e - 1) && g <= 16'(e + 1)) !== 1'b1) begin
      err_total++;
      $display("wrong value %s exp %0d got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge ref_clk);
    bus <= '0;
    #1 d = rdata;
  endtask
  task automatic rd_cnt(output logic [15:0] c);
    rd(STC1_OFF_LOW, c[7:0]);
    rd(STC1_OFF_HIGH, c[15:8]);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge ref_clk);
    err_total++;
    final_report();
  end
  initial begin
    logic [7:0] d;
    logic [15:0] c, v;
    int k, p;
    void'($urandom(32'ha5daf078));
    v = 16'($urandom());
    {lp_osc_in_pin, sysclk_from_lp_osc, power_managed_mode} <= v[2:0];
    osc_pin_direction_bits <= v[4:3];
    osc_pin_out_val <= v[6:5];
    compare_mode_field <= 4'h0;
    use_osc <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(STC1_OFF_CTRL, d);
    chk("ctrl rst", 16'(STC1_CTRL_RST), 16'(d));
    for (int i = 0; i < 6; i++) begin
      v = 16'($urandom());
      sysclk_from_lp_osc <= v[8];
      osc_pin_direction_bits <= v[10:9];
      power_managed_mode <= v[11];
      osc_pin_out_val <= v[13:12];
      lp_osc_in_pin <= v[14];
      wr(STC1_OFF_CTRL, v[7:0]);
      rd(STC1_OFF_CTRL, d);
      chk("ctrl", exp_ctl(v[7:0], v[8]), 16'(d));
      chk("oe_n", 16'(v[3] ? 2'b11 : v[10:9]), 16'(osc_pin_oe_n));
      chk("pin rd", 16'h0000, 16'(osc_pin_read));
      chk("pin out", 16'(v[13:12]), 16'(osc_pin_out));
      chk("osc run", 16'(v[3]), 16'(lp_osc_running));
    end
    $display("t1 done");
    wr(STC1_OFF_CTRL, 8'h00);
    repeat (4) begin
      v = 16'($urandom());
      wr(STC1_OFF_HIGH, v[15:8]);
      wr(STC1_OFF_LOW, v[7:0]);
      rd_cnt(c);
      chk("count", v, c);
    end
    for (p = 0; p < 4; p++) begin
      wr(STC1_OFF_HIGH, 8'h00);
      wr(STC1_OFF_LOW, 8'h00);
      wr(STC1_OFF_CTRL, {2'b00, 2'(p), 4'h5});
      repeat (40 << p) @(posedge ref_clk);
      wr(STC1_OFF_CTRL, 8'h00);
      rd_cnt(c);
      chk_near("ticks", 10, c);
      repeat (20) @(posedge ref_clk);
      rd_cnt(v);
      chk("stopped", c, v);
    end
    $display("t2 done");
    for (int m = 0; m < 3; m++) begin
      p = $urandom_range(3);
      k = 8 + $urandom_range(16);
      use_osc <= (m == 2);
      wr(STC1_OFF_LOW, 8'h00);
      wr(STC1_OFF_CTRL, {2'b00, 2'(p), m == 2, m == 1, 2'b11});
      i_stc1_far.edges(k);
      rd_cnt(c);
      chk("ext count", scaled(k, p), c);
    end
    use_osc <= 1'b0;
    wr(STC1_OFF_LOW, 8'h00);
    wr(STC1_OFF_CTRL, 8'h33);
    i_stc1_far.edges(5);
    wr(STC1_OFF_HIGH, 8'h40);
    i_stc1_far.edges(3);
    rd_cnt(c);
    chk("ps kept", 16'h4001, c);
    i_stc1_far.edges(5);
    wr(STC1_OFF_LOW, 8'h00);
    i_stc1_far.edges(3);
    rd_cnt(c);
    chk("ps clr", 16'h4000, c);
    $display("t3 done");
    wr(STC1_OFF_CTRL, 8'h03);
    wr(STC1_OFF_FLAGS, 8'h00);
    wr(STC1_OFF_HIGH, 8'hFF);
    wr(STC1_OFF_LOW, 8'hFE);
    i_stc1_far.edges(2);
    rd(STC1_OFF_FLAGS, d);
    chk("flag", 16'h0001, 16'(d));
    chk("irq off", 16'h0000, 16'(overflow_irq));
    wr(STC1_OFF_FLAGS, 8'h03);
    #1 chk("irq on", 16'h0001, 16'(overflow_irq));
    wr(STC1_OFF_FLAGS, 8'h02);
    rd(STC1_OFF_FLAGS, d);
    chk("flag clr", 16'h0002, 16'(d));
    wr(STC1_OFF_CTRL, 8'h00);
    wr(STC1_OFF_HIGH, 8'h12);
    wr(STC1_OFF_LOW, 8'h77);
    compare_mode_field <= STC1_TRIG_MODE;
    i_stc1_far.pulse();
    rd_cnt(c);
    chk("trig", 16'h0000, c);
    rd(STC1_OFF_FLAGS, d);
    chk("trig flag", 16'h0002, 16'(d));
    compare_mode_field <= 4'(STC1_TRIG_MODE + 4'(1 + $urandom_range(14)));
    wr(STC1_OFF_LOW, 8'h02);
    i_stc1_far.pulse();
    rd_cnt(c);
    chk("no trig", 16'h0002, c);
    compare_mode_field <= STC1_TRIG_MODE;
    fork
      wr(STC1_OFF_LOW, 8'h5A);
      i_stc1_far.pulse();
    join
    rd_cnt(c);
    chk("wr wins", 16'h005A, c);
    $display("t4 done");
    wr(STC1_OFF_CTRL, 8'h80);
    v = 16'($urandom());
    wr(STC1_OFF_HIGH, v[15:8]);
    wr(STC1_OFF_LOW, v[7:0]);
    wr(STC1_OFF_HIGH, ~v[15:8]);
    rd(STC1_OFF_HIGH, d);
    chk("buf", {8'h00, ~v[15:8]}, 16'(d));
    rd_cnt(c);
    chk("wide", v, c);
    wr(STC1_OFF_CTRL, 8'h00);
    rd_cnt(c);
    chk("live", v, c);
    $display("t5 done");
    final_report();
  end
endmodule // tb
